// >>> common/prq_pkg.sv
// How it works
// - without request queue support every register reads zero and ignores writes
// - consumer offset sits in bits 18:5, software advances it after consuming
// - producer offset sits in bits 18:5, where hardware writes the next entry
// - queue base is bits 63:12 of the address register, 4KB aligned
// - base bits at or above the host address width are not kept
// - size code X gives 2^X pages, 2^(X+7) entries
// - overflow sets status bit 1; writing one clears it
// - the overflowing request and any while overflow stays set are discarded
// - overflow raises a page request event
// - each added entry sets status bit 0; writing one clears it
// - while the event mask is set, reset value one, the event message waits
// - a flag set while another status flag is set is no new event
package prq_pkg;
  localparam logic [11:0] OFF_CONSUMER_LO = 12'h0C0;
  localparam logic [11:0] OFF_CONSUMER_HI = 12'h0C4;
  localparam logic [11:0] OFF_PRODUCER_LO = 12'h0C8;
  localparam logic [11:0] OFF_PRODUCER_HI = 12'h0CC;
  localparam logic [11:0] OFF_BASE_LO     = 12'h0D0;
  localparam logic [11:0] OFF_BASE_HI     = 12'h0D4;
  localparam logic [11:0] OFF_STATUS      = 12'h0DC;
  localparam logic [11:0] OFF_EVENT_CTL   = 12'h0E0;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h0F0;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h0F4;
  localparam int OFS_LSB      = 5;
  localparam int OFS_MSB      = 18;
  localparam int OFS_W        = OFS_MSB - OFS_LSB + 1;
  localparam int BASE_LSB     = 12;
  localparam int SIZE_W       = 3;
  localparam int ENTRY_SHIFT  = 7;
  localparam int BIT_PENDING  = 0;
  localparam int BIT_OVERFLOW = 1;
  localparam int BIT_MASK     = 31;
  localparam int BIT_OUTSTAND = 30;
  localparam logic MASK_RESET = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } entry_write_t;
endpackage

// >>> hdl/sticky_flags.sv
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] setBits,
  input  wire logic [W-1:0] clearBits,
  output logic      [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } sticky_state_t;
  sticky_state_t state;
  sticky_state_t next_state;
  always_comb begin
    next_state = state;
    // set wins over clear
    next_state.flags = (state.flags & ~clearBits) | setBits;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign flags = state.flags;
  a_set_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (|setBits) |=> ((flags & $past(setBits)) == $past(setBits)))
    else $error("sticky set lost");
endmodule

// >>> hdl/page_request_queue_iface.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module page_request_queue_iface #(
  parameter int HOST_ADDR_WIDTH = 48
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  requestQueueSupported,
  input  wire prq_pkg::apb_req_t     apbReq,
  output prq_pkg::apb_rsp_t          apbRsp,
  input  wire logic                  pageRequest,
  output logic                       requestAccepted,
  output logic                       requestDiscarded,
  output prq_pkg::entry_write_t      entryWrite,
  output logic                       eventMessage,
  output logic                       irq
);
  import prq_pkg::*;

  typedef struct packed {
    apb_rsp_t                 rsp;
    logic [OFS_W-1:0]         consumerOffset;
    logic [OFS_W-1:0]         producerOffset;
    logic [63:BASE_LSB]       queueBaseAddress;
    logic [SIZE_W-1:0]        queueSizeCode;
    logic                     eventMask;
    logic                     eventOutstanding;
    logic                     accepted;
    logic                     discarded;
    entry_write_t             entry;
    logic                     message;
    logic [1:0]               irqMask;
    logic                     irq;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic [1:0]  statusFlags;
  logic [1:0]  statusSet;
  logic [1:0]  statusClear;
  logic [1:0]  irqFlags;
  logic [1:0]  irqSet;
  logic [1:0]  irqClear;

  logic             apbWrite;
  logic             apbRead;
  logic [OFS_W-1:0] entryMask;
  logic [OFS_W-1:0] advancedTail;
  logic             wouldOverflow;
  logic             acceptNow;
  logic             overflowNow;
  logic             newEvent;
  logic [63:0]      baseKept;

  sticky_flags #(.W(2)) u_status (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .setBits   (statusSet),
    .clearBits (statusClear),
    .flags     (statusFlags)
  );

  sticky_flags #(.W(2)) u_irq (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .setBits   (irqSet),
    .clearBits (irqClear),
    .flags     (irqFlags)
  );

  always_comb begin
    apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite && !state.rsp.pready;
    apbRead  = apbReq.psel && apbReq.penable && !apbReq.pwrite && !state.rsp.pready;
    // entries = 2^(X+7); offset counts 32-byte entries
    entryMask = OFS_W'((32'h00000001 << (32'(state.queueSizeCode) + ENTRY_SHIFT)) - 1);
    advancedTail  = (state.producerOffset + OFS_W'(1)) & entryMask;
    wouldOverflow = (advancedTail == state.consumerOffset);
    acceptNow   = pageRequest && requestQueueSupported && !statusFlags[BIT_OVERFLOW]
                  && !wouldOverflow;
    overflowNow = pageRequest && requestQueueSupported && !statusFlags[BIT_OVERFLOW]
                  && wouldOverflow;
    statusSet = {overflowNow, acceptNow};
    statusClear = '0;
    irqClear    = '0;
    if (apbWrite && requestQueueSupported && apbReq.paddr == OFF_STATUS) begin
      statusClear = apbReq.pwdata[1:0];
    end
    if (apbWrite && requestQueueSupported && apbReq.paddr == OFF_IRQ_STATUS) begin
      irqClear = apbReq.pwdata[1:0];
    end
    irqSet = statusSet;
    // only a set with every flag clear is a fresh event
    newEvent = (|statusSet) && (statusFlags == 2'b00);
    baseKept = '0;
    baseKept[HOST_ADDR_WIDTH-1:BASE_LSB] = state.queueBaseAddress[HOST_ADDR_WIDTH-1:BASE_LSB];
  end

  always_comb begin
    next_state = state;
    next_state.rsp.pready  = 1'b0;
    next_state.rsp.pslverr = 1'b0;
    next_state.rsp.prdata  = ZERO_WORD;
    next_state.accepted    = acceptNow;
    next_state.discarded   = overflowNow || (pageRequest && statusFlags[BIT_OVERFLOW]);
    next_state.message     = 1'b0;
    next_state.entry.valid = acceptNow;
    next_state.entry.addr  = baseKept | 64'({state.producerOffset, 5'h00});
    if (acceptNow) begin
      next_state.producerOffset = advancedTail;
    end
    if (newEvent) begin
      next_state.eventOutstanding = 1'b1;
    end
    if (state.eventOutstanding && !state.eventMask) begin
      next_state.message          = 1'b1;
      next_state.eventOutstanding = newEvent;
    end
    if (state.eventOutstanding && !statusFlags[BIT_PENDING] && !statusFlags[BIT_OVERFLOW]
        && !newEvent) begin
      next_state.eventOutstanding = 1'b0;
    end
    if (apbReq.psel && apbReq.penable && !state.rsp.pready) begin
      next_state.rsp.pready = 1'b1;
    end
    if (apbWrite && requestQueueSupported) begin
      unique case (apbReq.paddr)
        OFF_CONSUMER_LO: next_state.consumerOffset = apbReq.pwdata[OFS_MSB:OFS_LSB];
        OFF_PRODUCER_LO: next_state.producerOffset = apbReq.pwdata[OFS_MSB:OFS_LSB];
        OFF_BASE_LO: begin
          next_state.queueBaseAddress[31:BASE_LSB] = apbReq.pwdata[31:BASE_LSB];
          next_state.queueSizeCode = apbReq.pwdata[SIZE_W-1:0];
        end
        OFF_BASE_HI: next_state.queueBaseAddress[63:32] = apbReq.pwdata;
        OFF_EVENT_CTL: next_state.eventMask = apbReq.pwdata[BIT_MASK];
        OFF_IRQ_MASK: next_state.irqMask = apbReq.pwdata[1:0];
        default: begin
        end
      endcase
    end
    if (apbRead && requestQueueSupported) begin
      unique case (apbReq.paddr)
        OFF_CONSUMER_LO: next_state.rsp.prdata[OFS_MSB:OFS_LSB] = state.consumerOffset;
        OFF_PRODUCER_LO: next_state.rsp.prdata[OFS_MSB:OFS_LSB] = state.producerOffset;
        OFF_BASE_LO: begin
          next_state.rsp.prdata[31:BASE_LSB] = baseKept[31:BASE_LSB];
          next_state.rsp.prdata[SIZE_W-1:0]  = state.queueSizeCode;
        end
        OFF_BASE_HI: next_state.rsp.prdata = baseKept[63:32];
        OFF_STATUS: next_state.rsp.prdata[1:0] = statusFlags;
        OFF_EVENT_CTL: begin
          next_state.rsp.prdata[BIT_MASK]    = state.eventMask;
          next_state.rsp.prdata[BIT_OUTSTAND] = state.eventOutstanding;
        end
        OFF_IRQ_STATUS: next_state.rsp.prdata[1:0] = irqFlags;
        OFF_IRQ_MASK: next_state.rsp.prdata[1:0] = state.irqMask;
        default: begin
        end
      endcase
    end
    next_state.irq = |((irqFlags & ~irqClear | irqSet) & state.irqMask);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state           <= '0;
      state.eventMask <= MASK_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign apbRsp           = state.rsp;
  assign requestAccepted  = state.accepted;
  assign requestDiscarded = state.discarded;
  assign entryWrite       = state.entry;
  assign eventMessage     = state.message;
  assign irq              = state.irq;

  sequence s_request_while_overflow;
    pageRequest && statusFlags[BIT_OVERFLOW];
  endsequence

  a_unsupported_reads_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!requestQueueSupported && apbRead) |=> (apbRsp.prdata == ZERO_WORD))
    else $error("unsupported register read not zero");
  a_no_enqueue_overflow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_request_while_overflow |=> (!requestAccepted && requestDiscarded))
    else $error("request enqueued during overflow");
  a_tail_advances: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acceptNow && !apbWrite) |=> (state.producerOffset == $past(advancedTail)))
    else $error("tail did not advance");
  a_overflow_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    overflowNow |=> statusFlags[BIT_OVERFLOW])
    else $error("overflow flag not set");
  a_pending_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acceptNow |=> (statusFlags[BIT_PENDING] && entryWrite.valid))
    else $error("pending flag not set on entry");
  a_mask_holds_msg: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state.eventMask |=> !eventMessage)
    else $error("message sent while masked");
  a_entry_address: assert property (@(posedge sys_clk) disable iff (!reset_n)
    acceptNow |=> (entryWrite.addr[11:0] == {$past(state.producerOffset[6:0]), 5'h00}))
    else $error("entry address wrong");
  a_no_new_event: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ((|statusSet) && (statusFlags != 2'b00) && !state.eventOutstanding)
      |=> !state.eventOutstanding)
    else $error("event raised while flag already set");
  a_apb_one_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (apbReq.psel && apbReq.penable && !apbRsp.pready) |=> apbRsp.pready)
    else $error("apb answer late");

  sequence s_write_to(logic [11:0] a, logic extra);
    apbWrite && requestQueueSupported && (apbReq.paddr == a) && extra;
  endsequence

  sequence s_read_from(logic [11:0] a);
    apbRead && requestQueueSupported && (apbReq.paddr == a);
  endsequence

  a_overflow_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_STATUS, apbReq.pwdata[BIT_OVERFLOW] && !overflowNow)
      |=> !statusFlags[BIT_OVERFLOW])
    else $error("overflow flag not cleared by one");
  a_overflow_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_STATUS, !apbReq.pwdata[BIT_OVERFLOW] && statusFlags[BIT_OVERFLOW])
      |=> statusFlags[BIT_OVERFLOW])
    else $error("overflow flag cleared by zero");
  a_pending_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_STATUS, apbReq.pwdata[BIT_PENDING] && !acceptNow)
      |=> !statusFlags[BIT_PENDING])
    else $error("pending flag not cleared by one");
  a_consumer_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_CONSUMER_LO, 1'b1)
      |=> (state.consumerOffset == $past(apbReq.pwdata[OFS_MSB:OFS_LSB])))
    else $error("consumer offset write lost");
  a_producer_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_PRODUCER_LO, 1'b1)
      |=> (state.producerOffset == $past(apbReq.pwdata[OFS_MSB:OFS_LSB])))
    else $error("producer offset write lost");
  a_base_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_BASE_LO, 1'b1)
      |=> (state.queueBaseAddress[31:BASE_LSB] == $past(apbReq.pwdata[31:BASE_LSB])))
    else $error("queue base write lost");
  a_size_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_BASE_LO, 1'b1)
      |=> (state.queueSizeCode == $past(apbReq.pwdata[SIZE_W-1:0])))
    else $error("queue size write lost");
  a_mask_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_to(OFF_EVENT_CTL, 1'b1)
      |=> (state.eventMask == $past(apbReq.pwdata[BIT_MASK])))
    else $error("event mask write lost");

  a_status_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_from(OFF_STATUS) |=> (apbRsp.prdata == {30'h0, $past(statusFlags)}))
    else $error("status read wrong");
  a_consumer_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_from(OFF_CONSUMER_LO)
      |=> (apbRsp.prdata == (32'($past(state.consumerOffset)) << OFS_LSB)))
    else $error("consumer offset read wrong");
  a_producer_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_from(OFF_PRODUCER_LO)
      |=> (apbRsp.prdata == (32'($past(state.producerOffset)) << OFS_LSB)))
    else $error("producer offset read wrong");
  a_high_word_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_from(OFF_CONSUMER_HI) |=> (apbRsp.prdata == ZERO_WORD))
    else $error("consumer high word not zero");
  a_event_ctl_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_from(OFF_EVENT_CTL)
      |=> (apbRsp.prdata == {$past(state.eventMask), $past(state.eventOutstanding), 30'h0}))
    else $error("event control read wrong");
  a_base_high_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_from(OFF_BASE_HI) |=> (apbRsp.prdata == $past(baseKept[63:32])))
    else $error("queue base high read wrong");

  a_entry_aligned: assert property (@(posedge sys_clk) disable iff (!reset_n)
    entryWrite.valid |-> (entryWrite.addr[OFS_LSB-1:0] == '0))
    else $error("entry address not aligned");
  a_addr_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (entryWrite.addr >> HOST_ADDR_WIDTH) == 64'h0)
    else $error("entry address above host width");
  a_tail_wraps: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acceptNow && !apbWrite && (state.producerOffset == entryMask))
      |=> (state.producerOffset == '0))
    else $error("tail did not wrap");
  a_overflow_drops: assert property (@(posedge sys_clk) disable iff (!reset_n)
    overflowNow |=> (!entryWrite.valid && requestDiscarded))
    else $error("overflowing request enqueued");

  a_unsupported_frozen: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !requestQueueSupported |=> ($stable(state.consumerOffset) && $stable(state.producerOffset)
      && $stable(state.queueBaseAddress) && $stable(state.queueSizeCode)
      && $stable(state.eventMask) && $stable(state.irqMask)))
    else $error("register changed while unsupported");
  a_unsupported_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !requestQueueSupported |=> !requestAccepted)
    else $error("request taken while unsupported");

  a_message_unmasked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state.eventOutstanding && !state.eventMask) |=> eventMessage)
    else $error("unmasked event message not sent");
  a_overflow_event: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (overflowNow && (statusFlags == 2'b00)) |=> state.eventOutstanding)
    else $error("overflow raised no event");
  a_entry_event: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (acceptNow && (statusFlags == 2'b00)) |=> state.eventOutstanding)
    else $error("new entry raised no event");

  a_ready_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held too long");
  a_prdata_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !apbRsp.pready |-> (apbRsp.prdata == ZERO_WORD))
    else $error("read data outside answer");
  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq == |(irqFlags & $past(state.irqMask)))
    else $error("irq level wrong");
endmodule

// >>> testbench/queue_host_model.sv
`timescale 1ns/1ps
module queue_host_model (
  input  wire logic                  sys_clk,
  input  wire prq_pkg::entry_write_t entryWrite,
  input  wire logic                  requestAccepted,
  input  wire logic                  requestDiscarded,
  output logic                       pageRequest
);
  import prq_pkg::*;
  int          accepted = 0;
  int          discarded = 0;
  logic [63:0] lastAddr = '0;
  initial pageRequest = 1'b0;
  // one request, one cycle high, then room for the answer
  task automatic send();
    @(posedge sys_clk);
    pageRequest <= 1'b1;
    @(posedge sys_clk);
    pageRequest <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // entry memory: remember where the last entry landed
  always @(posedge sys_clk) begin
    if (requestAccepted === 1'b1) accepted++;
    if (requestDiscarded === 1'b1) discarded++;
    if (entryWrite.valid === 1'b1) lastAddr <= entryWrite.addr;
  end
endmodule

// >>> testbench/page_request_queue_iface_bench.sv
`timescale 1ns/1ps
module page_request_queue_iface_bench;
  import prq_pkg::*;
  localparam logic [63:0] BASE = 64'h0000FFFF_00005000;
  logic                sys_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                supported = 1'b1;
  apb_req_t            req = '0;
  apb_rsp_t            rsp;
  logic                pageRequest;
  logic                accepted;
  logic                discarded;
  entry_write_t        entryWrite;
  logic                eventMessage;
  logic                irq;
  int                  fails = 0;
  int                  checkCount = 0;
  int                  evCount = 0;
  logic [31:0]         q;
  initial forever #2 sys_clk = ~sys_clk;
  page_request_queue_iface dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .requestQueueSupported(supported), .apbReq(req), .apbRsp(rsp),
    .pageRequest(pageRequest), .requestAccepted(accepted), .requestDiscarded(discarded),
    .entryWrite(entryWrite), .eventMessage(eventMessage), .irq(irq));
  queue_host_model host (.sys_clk(sys_clk), .entryWrite(entryWrite),
    .requestAccepted(accepted), .requestDiscarded(discarded), .pageRequest(pageRequest));
  always @(posedge sys_clk) if (eventMessage === 1'b1) evCount++;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) fails++;
    q = rsp.prdata;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc(OFF_EVENT_CTL, 32'h80000000);
    rdc(OFF_STATUS, 32'h0);
    apb(1'b1, OFF_BASE_LO, 32'h00005FF8);
    rdc(OFF_BASE_LO, 32'h00005000);
    apb(1'b1, OFF_BASE_HI, 32'hFFFFFFFF);
    rdc(OFF_BASE_HI, 32'h0000FFFF);
    apb(1'b1, OFF_CONSUMER_LO, 32'hFFFFFFFF);
    rdc(OFF_CONSUMER_LO, 32'h0007FFE0);
    rdc(OFF_CONSUMER_HI, 32'h0);
    apb(1'b1, OFF_CONSUMER_LO, 32'h40);
    apb(1'b1, OFF_PRODUCER_LO, 32'hFC0);
    rdc(OFF_PRODUCER_LO, 32'hFC0);
    host.send();
    chk(host.lastAddr, BASE | 64'hFC0);
    host.send();
    chk(host.lastAddr, BASE | 64'hFE0);
    host.send();
    chk(host.lastAddr, BASE);
    chk(64'(host.accepted), 64'd3);
    host.send();
    chk(64'(host.discarded), 64'd1);
    rdc(OFF_STATUS, 32'h3);
    rdc(OFF_PRODUCER_LO, 32'h20);
    host.send();
    chk(64'(host.discarded), 64'd2);
    chk(64'(evCount), 64'd0);
    rdc(OFF_EVENT_CTL, 32'hC0000000);
    apb(1'b1, OFF_STATUS, 32'h2);
    rdc(OFF_STATUS, 32'h1);
    apb(1'b1, OFF_EVENT_CTL, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk(64'(evCount), 64'd1);
    rdc(OFF_EVENT_CTL, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h3);
    apb(1'b1, OFF_CONSUMER_LO, 32'h60);
    host.send();
    chk(64'(host.accepted), 64'd4);
    rdc(OFF_STATUS, 32'h1);
    host.send();
    chk(64'(evCount), 64'd2);
    chk(64'(host.discarded), 64'd3);
    chk({63'h0, irq}, 64'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({63'h0, irq}, 64'h1);
    apb(1'b1, OFF_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk({63'h0, irq}, 64'h0);
    rdc(12'h0D8, 32'h0);
    supported <= 1'b0;
    rdc(OFF_CONSUMER_LO, 32'h0);
    apb(1'b1, OFF_CONSUMER_LO, 32'h0);
    host.send();
    chk(64'(host.accepted), 64'd4);
    chk(64'(host.discarded), 64'd4);
    supported <= 1'b1;
    rdc(OFF_CONSUMER_LO, 32'h60);
    final_report();
  end
endmodule
